/* inc/tfcc_pkg.sv */
// Package for the thermal flag and current compensation block.
// Assumes ratiometric ADC codes for sense pins, full scale = supply.
package tfcc_pkg;

  // ==========================================================
  // Converter widths
  localparam int RATIO_W  = 10;
  localparam int TEMP_W   = 6;
  localparam int FACTOR_W = 4;
  localparam int CUR_W    = 16;
  localparam int GAIN_W   = 12;
  localparam int GAIN_FRAC = 10;

  // ==========================================================
  // Thresholds as fraction of supply: flags in tenths of a percent, compensation enable as a divisor
  localparam int FAN_SET_PM   = 391;
  localparam int FAN_CLR_PM   = 451;
  localparam int HOT_SET_PM   = 333;
  localparam int HOT_CLR_PM   = 391;
  localparam int COMP_EN_DIV  = 15;

  function automatic logic [RATIO_W-1:0] frac_code(input int pm);
    frac_code = RATIO_W'((pm * (1 << RATIO_W)) / 1000);
  endfunction : frac_code

  localparam logic [RATIO_W-1:0] FAN_SET_CODE = frac_code(FAN_SET_PM);
  localparam logic [RATIO_W-1:0] FAN_CLR_CODE = frac_code(FAN_CLR_PM);
  localparam logic [RATIO_W-1:0] HOT_SET_CODE = frac_code(HOT_SET_PM);
  localparam logic [RATIO_W-1:0] HOT_CLR_CODE = frac_code(HOT_CLR_PM);
  localparam logic [RATIO_W-1:0] COMP_EN_CODE =
    RATIO_W'(((1 << RATIO_W) + COMP_EN_DIV - 1) / COMP_EN_DIV);

  localparam logic [FACTOR_W-1:0] FACTOR_EQUAL = 4'h4;
  localparam logic [FACTOR_W-1:0] FACTOR_OFF   = 4'h0;
  localparam logic [GAIN_W-1:0]   GAIN_UNITY   = 12'h400;

  // ==========================================================
  // Register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;
  localparam logic [3:0] REG_CODES  = 4'h3;
  localparam logic [3:0] REG_CUR    = 4'h4;
  localparam int ST_FAN_RISE = 0;
  localparam int ST_HOT_RISE = 1;
  localparam int ST_HOT_FALL = 2;
  localparam int ST_W        = 3;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
  localparam logic            CTRL_RESET = 1'b0;

  typedef struct packed {
    logic [TEMP_W-1:0]   temp_code;
    logic [FACTOR_W-1:0] factor;
    logic                comp_on;
  } tfcc_codes_type;

  typedef struct packed {
    logic fan_raise;
    logic hot_raise;
  } tfcc_flags_type;

endpackage : tfcc_pkg

/* verification/tfcc_sys_model.sv */
// Far-side model: fan control and processor throttle input.
// Assumes each flag arrives as data plus a pull-low enable.
`timescale 1ns/10ps
`default_nettype none
module tfcc_sys_model (
  input  wire logic cool_data_in,
  input  wire logic cool_oe_in,
  input  wire logic alarm_data_in,
  input  wire logic alarm_oe_in,
  output logic      fan_boost_out,
  output logic      throttle_out
);
  // ==========================================
  // Board pull-ups on both flag lines
  logic cooling_line;
  logic cpu_throttle_in;
  assign cooling_line    = cool_oe_in ? cool_data_in : 1'b1;
  assign cpu_throttle_in = alarm_oe_in ? alarm_data_in : 1'b1;
  assign fan_boost_out   = cooling_line;
  assign throttle_out    = cpu_throttle_in;
endmodule : tfcc_sys_model
`default_nettype wire

/* verification/tfcc_tb_top.sv */
// Bench for the thermal flag and compensation block.
// Assumes a 125 MHz clock and the pull-up model on the flags.
`timescale 1ns/10ps
`default_nettype none
module tfcc_tb_top;
  import tfcc_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic               clk         = 1'b0;
  logic               rstn        = 1'b0;
  logic [RATIO_W-1:0] sense       = 10'h064;
  logic [RATIO_W-1:0] offs        = 10'h000;
  logic [CUR_W-1:0]   cur         = 16'h0000;
  logic [3:0]         addr        = 4'h0;
  logic [31:0]        wdata       = 32'h0;
  logic               wr          = 1'b0;
  logic               rd          = 1'b0;
  logic [31:0]        rdata;
  logic [CUR_W-1:0]   report;
  logic               irq, cool, cool_oe, alarm, alarm_oe, oc;
  logic               fan_on, throttle;
  logic [31:0]        d, t;
  int                 fail_count  = 0;
  int                 comparisons = 0;

  always #4 clk = ~clk;

  tfcc_top tfcc_top_i (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .THERMISTOR_SENSE_IN(sense),
    .COMP_OFFSET_SELECT_IN(offs), .SENSED_CURRENT_IN(cur),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .IRQ_OUT(irq), .COOLING_REQUEST_OUT(cool),
    .COOLING_REQUEST_OE_OUT(cool_oe), .THERMAL_ALARM_OUT(alarm),
    .THERMAL_ALARM_OE_OUT(alarm_oe), .LOAD_CURRENT_REPORT_OUT(report),
    .OVERCURRENT_OUT(oc));

  tfcc_sys_model tfcc_sys_model_i (
    .cool_data_in(cool), .cool_oe_in(cool_oe), .alarm_data_in(alarm),
    .alarm_oe_in(alarm_oe), .fan_boost_out(fan_on),
    .throttle_out(throttle));

  // ==========================================
  // Bus and compare helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic set_in(input logic [9:0] s, input logic [9:0] o,
                        input logic [15:0] c);
    @(posedge clk);
    sense <= s;
    offs  <= o;
    cur   <= c;
    tick(5);
    #1;
  endtask : set_in

  // ==========================================
  // Scenarios
  task automatic s_regs();
    rd_reg(REG_MASK, d);
    chk(d, 32'h0);
    wr_reg(4'hf, 32'hffff_ffff);
    rd_reg(4'hf, d);
    chk(d, 32'h0);
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0);
  endtask : s_regs

  task automatic s_enable();
    chk(32'({fan_on, throttle}), 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    tick(3);
    chk(32'({fan_on, throttle}), 32'h3);
    set_in(10'h258, 10'h000, 16'h0000);
    chk(32'({fan_on, throttle}), 32'h0);
  endtask : s_enable

  task automatic s_hyst();
    logic [9:0] lv [6] = '{10'h186, 10'h14a, 10'h172,
                           10'h1a4, 10'h1c2, 10'h1d6};
    logic [1:0] ex [6] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0};
    foreach (lv[i]) begin
      set_in(lv[i], 10'h000, 16'h0000);
      chk(32'({fan_on, throttle}), 32'(ex[i]));
    end
    chk(32'({cool, alarm}), 32'h0);
  endtask : s_hyst

  task automatic s_irq();
    rd_reg(REG_STATUS, d);
    chk(d, 32'h7);
    wr_reg(REG_MASK, 32'h1);
    tick(2);
    chk(32'(irq), 32'h1);
    wr_reg(REG_STATUS, 32'h7);
    tick(2);
    chk(32'(irq), 32'h0);
    set_in(10'h186, 10'h000, 16'h0000);
    chk(32'(irq), 32'h1);
    wr_reg(REG_MASK, 32'h0);
    tick(2);
    chk(32'(irq), 32'h0);
  endtask : s_irq

  task automatic s_comp();
    set_in(10'h258, 10'h000, 16'h1234);
    chk(32'(report), 32'h1234);
    chk(32'(oc), 32'h0);
    rd_reg(REG_CUR, d);
    chk(d, 32'h1234);
    set_in(10'h258, 10'h000, 16'hf001);
    chk(32'(oc), 32'h1);
    set_in(10'h258, 10'h044, 16'h1234);
    chk(32'(report), 32'h1234);
    rd_reg(REG_CODES, d);
    chk(32'(d[10:6]), 32'h01);
    set_in(10'h258, 10'h045, 16'h1234);
    rd_reg(REG_CODES, d);
    chk(32'(d[10:6]), 32'h11);
    set_in(10'h258, 10'h3ff, 16'h1234);
    rd_reg(REG_CODES, d);
    chk(32'(d[10:6]), 32'h1f);
  endtask : s_comp

  task automatic s_temp();
    set_in(10'h0c8, 10'h000, 16'h0000);
    rd_reg(REG_CODES, t);
    set_in(10'h2bc, 10'h000, 16'h0000);
    rd_reg(REG_CODES, d);
    chk(32'(t[5:0] > d[5:0]), 32'h1);
  endtask : s_temp

  // ==========================================
  // Verdict and run control
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_enable();
    s_hyst();
    s_irq();
    s_comp();
    s_temp();
    tally_and_finish();
  end
endmodule : tfcc_tb_top
`default_nettype wire

/* verilog/tfcc_gain.sv */
// Combinational gain lookup from compensation factor and temperature.
// Assumes codes are stable within the cycle they are sampled.
`timescale 1ns/10ps
`default_nettype none
module tfcc_gain
  import tfcc_pkg::*;
#(
  parameter int GAIN_STEP = 4
) (
  input  wire logic [TEMP_W-1:0]   temp_in,
  input  wire logic [FACTOR_W-1:0] factor_in,
  output logic      [GAIN_W-1:0]   gain_out
);
  // ==========================================================
  // Table: 1/(1+alpha*(T_csc-25)); T_csc offset by factor vs 4.
  // Exact values unknown, so the slope is a parameter.
  logic [GAIN_W-1:0] table_mem [16][64];

  function automatic logic [GAIN_W-1:0] gain_entry(input int f, input int t);
    int adj;
    int g;
    adj = t + (f - int'(FACTOR_EQUAL)) * 2;
    if (adj < 0) adj = 0;
    g = int'(GAIN_UNITY) - adj * GAIN_STEP;
    if (g < 256) g = 256;
    gain_entry = GAIN_W'(g);
  endfunction : gain_entry

  always_comb begin
    for (int f = 0; f < 16; f++) begin
      for (int t = 0; t < 64; t++) begin
        table_mem[f][t] = gain_entry(f, t);
      end
    end
  end

  assign gain_out = table_mem[factor_in][temp_in];
endmodule : tfcc_gain
`default_nettype wire

/* verilog/tfcc_top.sv */
// Thermal flags, temperature/offset digitising and current compensation.
// Assumes sense pins arrive as ratiometric codes synchronous to clock.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Both flags leave only as open-drain and mean nothing until enabled.
// - Cooling flag releases under 39.1% and pulls low above 45.1%.
// - Alarm flag releases under 33.3% and pulls low above 39.1%.
// - Compensation runs while offset select is at least supply/15.
// - Thermistor ratio becomes a 6-bit code linear in temperature.
// - Offset select ratio becomes a 4-bit factor from 0 to 15.
// - A factor of zero applies no compensation.
// - Factor 4 means equal temperatures; others shift the estimate.
// - The gain combines the factor with the temperature code.
// - Corrected current feeds both reporting and overcurrent checks.
module tfcc_top
  import tfcc_pkg::*;
#(
  parameter logic [CUR_W-1:0] OC_LIMIT = 16'hf000
) (
  input  wire logic                REF_CLK_IN,
  input  wire logic                RSTN_IN,
  input  wire logic [RATIO_W-1:0]  THERMISTOR_SENSE_IN,
  input  wire logic [RATIO_W-1:0]  COMP_OFFSET_SELECT_IN,
  input  wire logic [CUR_W-1:0]    SENSED_CURRENT_IN,
  input  wire logic [3:0]          ADDR_IN,
  input  wire logic [31:0]         WDATA_IN,
  input  wire logic                WR_IN,
  input  wire logic                RD_IN,
  output logic      [31:0]         RDATA_OUT,
  output logic                     IRQ_OUT,
  output logic                     COOLING_REQUEST_OUT,
  output logic                     COOLING_REQUEST_OE_OUT,
  output logic                     THERMAL_ALARM_OUT,
  output logic                     THERMAL_ALARM_OE_OUT,
  output logic      [CUR_W-1:0]    LOAD_CURRENT_REPORT_OUT,
  output logic                     OVERCURRENT_OUT
);

  // ==========================================================
  // Registers
  logic                 enable;
  logic [ST_W-1:0]      status;
  logic [ST_W-1:0]      mask;
  tfcc_flags_type       flags;
  tfcc_codes_type       codes;
  logic [GAIN_W-1:0]    gain;
  logic [CUR_W-1:0]     report;

  // ==========================================================
  // Digitising
  function automatic logic [TEMP_W-1:0] temp_of(input logic [RATIO_W-1:0] r);
    // Piecewise NTC linearisation: lower ratio = hotter
    logic [RATIO_W-1:0] inv;
    logic [RATIO_W:0]   lin;
    inv = ~r;
    if (inv < 10'h200) lin = {1'b0, inv} >> 1;
    else               lin = {1'b0, inv} - 11'h100;
    temp_of = lin[RATIO_W-1 -: TEMP_W];
  endfunction : temp_of

  wire logic [TEMP_W-1:0]   next_temp;
  wire logic [FACTOR_W-1:0] next_factor;
  wire logic                next_comp_on;
  assign next_temp    = temp_of(THERMISTOR_SENSE_IN);
  assign next_factor  = COMP_OFFSET_SELECT_IN[RATIO_W-1 -: FACTOR_W];
  assign next_comp_on = (COMP_OFFSET_SELECT_IN >= COMP_EN_CODE) &&
                        (next_factor != FACTOR_OFF);

  // ==========================================================
  // Hysteresis flags
  wire logic next_fan;
  wire logic next_hot;
  assign next_fan = (THERMISTOR_SENSE_IN < FAN_SET_CODE) ? 1'b1 :
                    (THERMISTOR_SENSE_IN > FAN_CLR_CODE) ? 1'b0 :
                    flags.fan_raise;
  assign next_hot = (THERMISTOR_SENSE_IN < HOT_SET_CODE) ? 1'b1 :
                    (THERMISTOR_SENSE_IN > HOT_CLR_CODE) ? 1'b0 :
                    flags.hot_raise;

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      flags <= '0;
    end else if (!enable) begin
      flags <= '0;
    end else begin
      flags <= '{fan_raise: next_fan, hot_raise: next_hot};
    end
  end

  // open-drain: drive low only, never high
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      COOLING_REQUEST_OUT    <= 1'b0;
      COOLING_REQUEST_OE_OUT <= 1'b1;
      THERMAL_ALARM_OUT      <= 1'b0;
      THERMAL_ALARM_OE_OUT   <= 1'b1;
    end else begin
      COOLING_REQUEST_OUT    <= 1'b0;
      COOLING_REQUEST_OE_OUT <= !(enable && next_fan);
      THERMAL_ALARM_OUT      <= 1'b0;
      THERMAL_ALARM_OE_OUT   <= !(enable && next_hot);
    end
  end

  // ==========================================================
  // Compensation
  wire logic [GAIN_W-1:0] table_gain;
  tfcc_gain tfcc_gain_i (
    .temp_in   (codes.temp_code),
    .factor_in (codes.factor),
    .gain_out  (table_gain)
  );

  wire logic [CUR_W+GAIN_W-1:0] product;
  wire logic [CUR_W+GAIN_W-1:0] scaled;
  wire logic [CUR_W-1:0]        next_report;
  assign product = {{GAIN_W{1'b0}}, SENSED_CURRENT_IN} * {{CUR_W{1'b0}}, gain};
  assign scaled  = product >> GAIN_FRAC;
  // Saturate rather than wrap on a large gain
  assign next_report = (|scaled[CUR_W+GAIN_W-1:CUR_W]) ? '1 :
                       scaled[CUR_W-1:0];

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      codes <= '0;
      gain  <= GAIN_UNITY;
    end else begin
      codes <= '{temp_code: next_temp, factor: next_factor,
                 comp_on: next_comp_on};
      gain  <= codes.comp_on ? table_gain : GAIN_UNITY;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      report                  <= '0;
      LOAD_CURRENT_REPORT_OUT <= '0;
      OVERCURRENT_OUT         <= 1'b0;
    end else begin
      report                  <= next_report;
      LOAD_CURRENT_REPORT_OUT <= next_report;
      OVERCURRENT_OUT         <= enable && (next_report > OC_LIMIT);
    end
  end

  // ==========================================================
  // Events and register port
  wire logic [ST_W-1:0] events;
  wire logic [ST_W-1:0] w1c;
  wire logic [ST_W-1:0] next_status;
  assign events = {flags.hot_raise & ~next_hot & enable,
                   ~flags.hot_raise & next_hot & enable,
                   ~flags.fan_raise & next_fan & enable};
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_ctrl;
  assign wr_status = WR_IN && (ADDR_IN == REG_STATUS);
  assign wr_mask   = WR_IN && (ADDR_IN == REG_MASK);
  assign wr_ctrl   = WR_IN && (ADDR_IN == REG_CTRL);
  assign w1c = wr_status ? WDATA_IN[ST_W-1:0] : '0;
  // Set beats clear in the same cycle
  assign next_status = (status & ~w1c) | events;

  wire logic [31:0] rd_mux;
  assign rd_mux =
    (ADDR_IN == REG_STATUS) ? {29'h0, status} :
    (ADDR_IN == REG_MASK)   ? {29'h0, mask} :
    (ADDR_IN == REG_CTRL)   ? {31'h0, enable} :
    (ADDR_IN == REG_CODES)  ? {19'h0, flags, codes.comp_on,
                               codes.factor, codes.temp_code} :
    (ADDR_IN == REG_CUR)    ? {16'h0, report} : 32'h0;

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      status    <= '0;
      mask      <= MASK_RESET;
      enable    <= CTRL_RESET;
      RDATA_OUT <= '0;
      IRQ_OUT   <= 1'b0;
    end else begin
      status    <= next_status;
      if (wr_mask) mask <= WDATA_IN[ST_W-1:0];
      if (wr_ctrl) enable <= WDATA_IN[CTRL_EN_BIT];
      RDATA_OUT <= RD_IN ? rd_mux : 32'h0;
      IRQ_OUT   <= |(next_status & mask);
    end
  end

  // ==========================================================
  // Checks
  sequence s_disabled;
    !enable;
  endsequence

  sequence s_fan_hot_zone;
    enable && (THERMISTOR_SENSE_IN < FAN_SET_CODE);
  endsequence

  sequence s_fan_cool_zone;
    THERMISTOR_SENSE_IN > FAN_CLR_CODE;
  endsequence

  sequence s_alarm_hot_zone;
    enable && (THERMISTOR_SENSE_IN < HOT_SET_CODE);
  endsequence

  sequence s_alarm_cool_zone;
    THERMISTOR_SENSE_IN > HOT_CLR_CODE;
  endsequence

  // Factor lands in codes one edge, the gain the edge after
  sequence s_factor_zero;
    COMP_OFFSET_SELECT_IN[RATIO_W-1 -: FACTOR_W] == FACTOR_OFF;
  endsequence

  flags_off_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_disabled |=> COOLING_REQUEST_OE_OUT && THERMAL_ALARM_OE_OUT)
    else $error("flag released while disabled");

  od_low_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !COOLING_REQUEST_OUT && !THERMAL_ALARM_OUT)
    else $error("open-drain pin driven high");

  fan_set_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_fan_hot_zone |=> !COOLING_REQUEST_OE_OUT)
    else $error("cooling flag not released");

  fan_clr_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_fan_cool_zone |=> COOLING_REQUEST_OE_OUT)
    else $error("cooling flag not pulled low");

  hot_set_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_alarm_hot_zone |=> !THERMAL_ALARM_OE_OUT)
    else $error("alarm not released");

  hot_clr_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_alarm_cool_zone |=> THERMAL_ALARM_OE_OUT)
    else $error("alarm not pulled low");

  gain_off_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_factor_zero |=> ##1 gain == GAIN_UNITY)
    else $error("gain applied with factor zero");

  oc_report_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    OVERCURRENT_OUT |-> $past(enable) && LOAD_CURRENT_REPORT_OUT > OC_LIMIT)
    else $error("overcurrent disagrees with report");

  comp_below_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    COMP_OFFSET_SELECT_IN < COMP_EN_CODE |=> !codes.comp_on)
    else $error("compensation on below threshold");

  comp_above_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    COMP_OFFSET_SELECT_IN >= COMP_EN_CODE |=> codes.comp_on)
    else $error("compensation off above threshold");

  gain_bypass_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !codes.comp_on |=> gain == GAIN_UNITY)
    else $error("gain applied while compensation off");

  oc_disabled_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    s_disabled |=> !OVERCURRENT_OUT)
    else $error("overcurrent while disabled");

  zero_report_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    SENSED_CURRENT_IN == '0 |=> LOAD_CURRENT_REPORT_OUT == '0)
    else $error("report nonzero for zero current");

  flag_pins_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (flags.fan_raise ^ COOLING_REQUEST_OE_OUT) &&
    (flags.hot_raise ^ THERMAL_ALARM_OE_OUT))
    else $error("flag pin differs from flag register");

  fan_event_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    enable && !flags.fan_raise && (THERMISTOR_SENSE_IN < FAN_SET_CODE)
    |=> status[ST_FAN_RISE])
    else $error("cooling event not recorded");

  alarm_event_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    enable && !flags.hot_raise && (THERMISTOR_SENSE_IN < HOT_SET_CODE)
    |=> status[ST_HOT_RISE])
    else $error("alarm event not recorded");

endmodule : tfcc_top
`default_nettype wire
